// ==== pmsu_pkg.sv ====
// Package: register map, field positions and constants of the power monitor status block
`default_nettype none
package pmsu_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h2D;
	localparam logic [ADDR_W-1:0] OFF_KEY      = 8'h2F;
	localparam logic [ADDR_W-1:0] OFF_CUST     = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 8'h41;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLR  = 8'h42;
	localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h43;
	localparam int unsigned STATUS_W = 7;
	localparam int unsigned BIT_ZC   = 0;
	localparam int unsigned BIT_OCL  = 1;
	localparam int unsigned BIT_OCS  = 2;
	localparam int unsigned BIT_OV   = 3;
	localparam int unsigned BIT_UV   = 4;
	localparam int unsigned BIT_ANG  = 5;
	localparam int unsigned BIT_PF   = 6;
	localparam int unsigned CTRL_HALF = 0;
	localparam int unsigned CTRL_SQ   = 1;
	localparam int unsigned CTRL_W    = 2;
	localparam int unsigned IRQ_W     = 5;
	localparam int unsigned IRQ_ZC    = 0;
	localparam int unsigned IRQ_OC    = 1;
	localparam int unsigned IRQ_OV    = 2;
	localparam int unsigned IRQ_UV    = 3;
	localparam int unsigned IRQ_KEY   = 4;
	localparam logic [DATA_W-1:0] CUSTOMER_CODE = 32'h4F70656E;
	localparam logic [DATA_W-1:0] KEY_RESET     = 32'h00000000;
	localparam logic [CTRL_W-1:0] CTRL_RESET    = 2'h0;
	localparam logic [DATA_W-1:0] READ_ZERO     = 32'h00000000;
endpackage
`default_nettype wire

// ==== pmsu_sync_if.sv ====
// Interface: synchronised condition levels passed from the input stage to the register bank
`default_nettype none
interface pmsu_sync_if;
	logic zc_raw;
	logic oc;
	logic ov;
	logic uv;
	logic ang;
	logic pf;
	modport src (output zc_raw, oc, ov, uv, ang, pf);
	modport dst (input zc_raw, oc, ov, uv, ang, pf);
endinterface
`default_nettype wire

// ==== pmsu_sync.sv ====
// Three-stage synchroniser for the raw condition inputs
`default_nettype none
module pmsu_sync #(
	parameter int unsigned N = 6
) (
	input  wire logic         core_clk_in,
	input  wire logic         resetn_in,
	input  wire logic         clk_en_in,
	input  wire logic [N-1:0] raw_in,
	pmsu_sync_if.src          sy
);
	logic [N-1:0] s1_reg;
	logic [N-1:0] s2_reg;
	logic [N-1:0] s3_reg;
	logic [N-1:0] val_reg;

	// Stage one feeds stage two only; a level counts once stages two and three agree
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			val_reg <= '0;
		end else if (clk_en_in) begin
			s1_reg <= raw_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < N; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					val_reg[i] <= s3_reg[i];
				end
			end
		end
	end

	assign sy.zc_raw = val_reg[0];
	assign sy.oc     = val_reg[1];
	assign sy.ov     = val_reg[2];
	assign sy.uv     = val_reg[3];
	assign sy.ang    = val_reg[4];
	assign sy.pf     = val_reg[5];
endmodule
`default_nettype wire

// ==== pmsu_top.sv ====
// Status flags, unlock key, customer mode and interrupt register bank
`default_nettype none
module pmsu_top
	import pmsu_pkg::*;
(
	input  wire logic                       core_clk_in,
	input  wire logic                       resetn_in,
	input  wire logic                       clk_en_in,
	input  wire logic [pmsu_pkg::ADDR_W-1:0] addr_in,
	input  wire logic [pmsu_pkg::DATA_W-1:0] wdata_in,
	input  wire logic                       wr_in,
	input  wire logic                       rd_in,
	output logic      [pmsu_pkg::DATA_W-1:0] rdata_out,
	input  wire logic                       zero_cross_in,
	input  wire logic                       overcurrent_in,
	input  wire logic                       overvoltage_in,
	input  wire logic                       undervoltage_in,
	input  wire logic                       current_lags_in,
	input  wire logic                       power_consumed_in,
	input  wire logic [1:0]                 pin_a_function_select_in,
	input  wire logic [1:0]                 pin_b_function_select_in,
	output logic                            customer_mode_out,
	output logic                            irq_out
);
	import pmsu_pkg::*;

	pmsu_sync_if sy ();

	logic [DATA_W-1:0]   key_reg;
	logic [CTRL_W-1:0]   ctrl_reg;
	logic                zc_prev_reg;
	logic                zc_flag_reg;
	logic                sticky_reg;
	logic                cust_reg;
	logic [IRQ_W-1:0]    irq_stat_reg;
	logic [IRQ_W-1:0]    irq_en_reg;
	logic [DATA_W-1:0]   rdata_reg;
	logic [STATUS_W-1:0] status;
	logic                zc_rise;
	logic                zc_edge;
	logic                oc_rise;
	logic                ov_rise;
	logic                uv_rise;
	logic                ocl_prev_reg;
	logic                ov_prev_reg;
	logic                uv_prev_reg;
	logic                key_hit;
	logic                key_rise;
	logic [IRQ_W-1:0]    irq_events;

	function automatic logic wr_at(input logic [ADDR_W-1:0] off);
		return wr_in && (addr_in == off);
	endfunction

	// Pin selects deliberately unused: flags are generated independently of pin routing
	pmsu_sync #(
		.N (6)
	) u_sync (
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.clk_en_in   (clk_en_in),
		.raw_in      ({power_consumed_in, current_lags_in, undervoltage_in,
		               overvoltage_in, overcurrent_in, zero_cross_in}),
		.sy          (sy.src)
	);

	assign zc_rise = sy.zc_raw && !zc_prev_reg;
	assign zc_edge = sy.zc_raw != zc_prev_reg;
	assign oc_rise = sy.oc && !ocl_prev_reg;
	assign ov_rise = sy.ov && !ov_prev_reg;
	assign uv_rise = sy.uv && !uv_prev_reg;

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			zc_prev_reg  <= 1'b0;
			ocl_prev_reg <= 1'b0;
			ov_prev_reg  <= 1'b0;
			uv_prev_reg  <= 1'b0;
		end else if (clk_en_in) begin
			zc_prev_reg  <= sy.zc_raw;
			ocl_prev_reg <= sy.oc;
			ov_prev_reg  <= sy.ov;
			uv_prev_reg  <= sy.uv;
		end
	end

	// Square-wave mode shows the polarity level; otherwise a one-cycle pulse per rising edge, or per edge in half-cycle mode
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			zc_flag_reg <= 1'b0;
		end else if (clk_en_in) begin
			if (ctrl_reg[CTRL_SQ]) begin
				zc_flag_reg <= sy.zc_raw;
			end else if (ctrl_reg[CTRL_HALF]) begin
				zc_flag_reg <= zc_edge;
			end else begin
				zc_flag_reg <= zc_rise;
			end
		end
	end

	// Set wins over a simultaneous write-1 clear so no event is lost
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			sticky_reg <= 1'b0;
		end else if (clk_en_in) begin
			if (sy.oc) begin
				sticky_reg <= 1'b1;
			end else if (wr_at(OFF_STATUS) && wdata_in[BIT_OCS]) begin
				sticky_reg <= 1'b0;
			end
		end
	end

	// Status word: zero-cross flag, sticky overcurrent and live bits straight from synchronised conditions
	always_comb begin
		status          = '0;
		status[BIT_ZC]  = zc_flag_reg;
		status[BIT_OCL] = sy.oc;
		status[BIT_OCS] = sticky_reg;
		status[BIT_OV]  = sy.ov;
		status[BIT_UV]  = sy.uv;
		status[BIT_ANG] = sy.ang;
		status[BIT_PF]  = sy.pf;
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			key_reg <= KEY_RESET;
		end else if (clk_en_in && wr_at(OFF_KEY)) begin
			key_reg <= wdata_in;
		end
	end

	assign key_hit  = key_reg == CUSTOMER_CODE;
	assign key_rise = key_hit && !cust_reg;

	// Indicator lags the key by one cycle, so it never shows before the code is held
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			cust_reg <= 1'b0;
		end else if (clk_en_in) begin
			cust_reg <= key_hit;
		end
	end

	assign customer_mode_out = cust_reg;

	// Control bits are writable only in customer mode
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			ctrl_reg <= CTRL_RESET;
		end else if (clk_en_in && wr_at(OFF_CTRL) && cust_reg) begin
			ctrl_reg <= wdata_in[CTRL_W-1:0];
		end
	end

	always_comb begin
		irq_events          = '0;
		irq_events[IRQ_ZC]  = zc_rise;
		irq_events[IRQ_OC]  = oc_rise;
		irq_events[IRQ_OV]  = ov_rise;
		irq_events[IRQ_UV]  = uv_rise;
		irq_events[IRQ_KEY] = key_rise;
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			irq_stat_reg <= '0;
		end else if (clk_en_in) begin
			if (wr_at(OFF_IRQ_CLR)) begin
				irq_stat_reg <= (irq_stat_reg & ~wdata_in[IRQ_W-1:0]) | irq_events;
			end else begin
				irq_stat_reg <= irq_stat_reg | irq_events;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			irq_en_reg <= '0;
		end else if (clk_en_in && wr_at(OFF_IRQ_EN)) begin
			irq_en_reg <= wdata_in[IRQ_W-1:0];
		end
	end

	assign irq_out = |(irq_stat_reg & irq_en_reg);

	// Reads only sample; no read clears anything
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			rdata_reg <= READ_ZERO;
		end else if (clk_en_in) begin
			rdata_reg <= READ_ZERO;
			if (rd_in) begin
				case (addr_in)
					OFF_STATUS:   rdata_reg <= {{(DATA_W-STATUS_W){1'b0}}, status};
					OFF_KEY:      rdata_reg <= key_reg;
					OFF_CUST:     rdata_reg <= {{(DATA_W-1){1'b0}}, cust_reg};
					OFF_IRQ_STAT: rdata_reg <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_reg};
					OFF_IRQ_EN:   rdata_reg <= {{(DATA_W-IRQ_W){1'b0}}, irq_en_reg};
					OFF_CTRL:     rdata_reg <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
					default:      rdata_reg <= READ_ZERO;
				endcase
			end
		end
	end

	assign rdata_out = rdata_reg;
endmodule
`default_nettype wire

// ==== pmsu_top_props.sv ====
// Checker: register bus, status flag and unlock properties of pmsu_top
`default_nettype none
module pmsu_props
	import pmsu_pkg::*;
(
	input wire logic              core_clk_in,
	input wire logic              resetn_in,
	input wire logic              clk_en_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic              wr_in,
	input wire logic              rd_in,
	input wire logic [DATA_W-1:0] rdata_out,
	input wire logic              overcurrent_in,
	input wire logic              overvoltage_in,
	input wire logic              power_consumed_in,
	input wire logic              customer_mode_out,
	input wire logic              irq_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk_in); endclocking
	// Frozen cycles break every fixed latency, so they disable the checks
	default disable iff (!resetn_in || !clk_en_in);
	wire logic st = rd_in && addr_in == OFF_STATUS;
	wire logic kw = wr_in && addr_in == OFF_KEY;
	// Seven quiet samples cover the four-edge synchroniser with margin
	property p_fl(c, int b);
		c [*7] ##0 st |=> rdata_out[b];
	endproperty
	chk_key_readback: assert property (kw ##1 rd_in && addr_in == OFF_KEY |=>
		rdata_out == $past(wdata_in, 2)) else $error("key readback wrong");
	chk_cust_read: assert property (rd_in && addr_in == OFF_CUST |=>
		rdata_out == {31'h0, $past(customer_mode_out)}) else $error("mode read wrong");
	chk_mode_after_key: assert property (kw && wdata_in == CUSTOMER_CODE |->
		##2 customer_mode_out) else $error("mode not entered");
	chk_mode_needs_key: assert property ($rose(customer_mode_out) |->
		$past(kw && wdata_in == CUSTOMER_CODE, 2)) else $error("mode without key");
	chk_live_oc_set: assert property (p_fl(overcurrent_in, 1)) else $error("live oc low");
	chk_live_oc_clear: assert property (!overcurrent_in [*7] ##0 st |=> !rdata_out[1])
		else $error("live oc stuck");
	chk_sticky_set: assert property (p_fl(overcurrent_in, 2)) else $error("sticky low");
	chk_ov_flag: assert property (p_fl(overvoltage_in, 3)) else $error("ov flag low");
	chk_pf_sign: assert property (p_fl(power_consumed_in, 6)) else $error("pf sign low");
	chk_read_keeps_sticky: assert property (st ##1 st && rdata_out[2] |=> rdata_out[2])
		else $error("read cleared sticky");
	cover property (customer_mode_out);
	cover property (irq_out);
	cover property (st ##1 rdata_out[2]);
endmodule
bind pmsu_top pmsu_props u_props (
	.core_clk_in       (core_clk_in),
	.resetn_in         (resetn_in),
	.clk_en_in         (clk_en_in),
	.addr_in           (addr_in),
	.wdata_in          (wdata_in),
	.wr_in             (wr_in),
	.rd_in             (rd_in),
	.rdata_out         (rdata_out),
	.overcurrent_in    (overcurrent_in),
	.overvoltage_in    (overvoltage_in),
	.power_consumed_in (power_consumed_in),
	.customer_mode_out (customer_mode_out),
	.irq_out           (irq_out)
);
`default_nettype wire

// ==== pmsu_top_test.sv ====
// Testbench: status flags, unlock key, customer mode and interrupt of pmsu_top
`default_nettype none
module pmsu_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import pmsu_pkg::*;
	logic              clk = 0, rstn = 0, wr = 0, rd = 0, sk = 0, cust, irq;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wd = '0, rdata, w, exp;
	logic [5:0]        cond = '0;
	logic [3:0]        sel = '0;
	int                fails = 0, checks = 0, cyc = 0;
	logic              en = 1, rd_seen = 0;
	logic [DATA_W-1:0] exq[$];
	always #10 clk = ~clk;
	pmsu_top dut (.core_clk_in(clk), .resetn_in(rstn), .clk_en_in(en), .addr_in(addr),
		.wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .zero_cross_in(cond[0]),
		.overcurrent_in(cond[1]), .overvoltage_in(cond[2]), .undervoltage_in(cond[3]),
		.current_lags_in(cond[4]), .power_consumed_in(cond[5]),
		.pin_a_function_select_in(sel[1:0]), .pin_b_function_select_in(sel[3:2]),
		.customer_mode_out(cust), .irq_out(irq));
	task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	// Strobes are left up so that requests can run back to back
	task automatic op(input logic wn, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		wr <= wn;
		rd <= !wn;
		addr <= a;
		wd <= d;
		@(posedge clk);
	endtask
	// Expected read data wait in a queue until the cycle in which the answer stands
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		exq.push_back(e);
		op(0, a, '0);
	endtask
	always @(posedge clk)
		rd_seen <= rd && en;
	// Sampled mid-cycle, where the registered read data have settled
	always @(negedge clk)
		if (rd_seen)
			chk(rdata, exq.pop_front());
	task automatic wt(input int n);
		wr <= 0;
		rd <= 0;
		repeat (n) @(posedge clk);
	endtask
	task automatic complete_run;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			fails++;
			complete_run;
		end
	end
	initial begin
		void'($urandom(32'h84AB));
		repeat (16) @(posedge clk);
		rstn <= 1;
		@(posedge clk);
		rdc(OFF_KEY, KEY_RESET);
		rdc(OFF_CUST, READ_ZERO);
		rdc(8'h10, READ_ZERO);
		op(1, OFF_KEY, 32'h1234ABCD);
		rdc(OFF_KEY, 32'h1234ABCD);
		rdc(OFF_CUST, READ_ZERO);
		op(1, OFF_KEY, CUSTOMER_CODE);
		wt(3);
		rdc(OFF_CUST, 32'h1);
		wt(1);
		#1 chk(cust, 32'h1);
		chk(irq, 32'h0);
		@(posedge clk);
		op(1, OFF_IRQ_EN, 32'h10);
		wt(1);
		#1 chk(irq, 32'h1);
		@(posedge clk);
		// Square-wave mode makes the zero-cross bit a readable level
		op(1, OFF_CTRL, 32'h2);
		op(1, OFF_IRQ_CLR, 32'h10);
		wt(1);
		#1 chk(irq, 32'h0);
		@(posedge clk);
		for (int i = 0; i < 12; i++) begin
			cond <= 6'($urandom);
			sel <= 4'($urandom);
			wt(10);
			sk = sk | cond[1];
			w = $urandom;
			op(1, OFF_STATUS, w);
			if (w[2] && !cond[1])
				sk = 0;
			exp = {25'h0, cond[5:2], sk, cond[1:0]};
			rdc(OFF_STATUS, exp);
			rdc(OFF_STATUS, exp);
		end
		// Pulse modes: the flag stands one cycle, so each read is timed to the crossing
		for (int m = 0; m < 2; m++) begin
			op(1, OFF_CTRL, m);
			cond <= '0;
			wt(8);
			for (int v = 1; v >= 0; v--) begin
				cond <= 6'(v);
				wt(5);
				rdc(OFF_STATUS, {29'h0, sk, 1'b0, 1'(v | m)});
				rdc(OFF_STATUS, {29'h0, sk, 2'b00});
			end
		end
		// A frozen cycle must not take the write
		en <= 0;
		op(1, OFF_KEY, 32'h13572468);
		en <= 1;
		rdc(OFF_KEY, CUSTOMER_CODE);
		op(1, OFF_KEY, KEY_RESET);
		wt(3);
		rdc(OFF_CUST, READ_ZERO);
		// Control writes are refused outside customer mode
		op(1, OFF_CTRL, 32'h3);
		rdc(OFF_CTRL, 32'h1);
		wt(2);
		complete_run;
	end
endmodule
`default_nettype wire
